//--- logic/tick_prescaler.sv
// tick divider with selectable ratio and synchronous clear
`default_nettype none
module tick_prescaler (
  // clock and reset
  input  wire logic       CLK,
  input  wire logic       RST,
  // control
  input  wire logic       clear,
  input  wire logic [1:0] ratio,
  // ticks
  input  wire logic       tick_in,
  output var  logic       tick_out
);
  import tmr_pkg::*;

  logic [PS_W-1:0] cnt_r;
  logic [PS_W-1:0] cnt_nxt;
  logic            out_r;
  logic            out_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    out_nxt = 1'b0;
    if (clear) begin
      cnt_nxt = PS_RST;
    end else if (tick_in) begin
      if (cnt_r >= ps_limit(ratio)) begin
        cnt_nxt = PS_RST;
        out_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + 8'h01;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      cnt_r <= PS_RST;
      out_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      out_r <= out_nxt;
    end
  end

  assign tick_out = out_r;
endmodule
`default_nettype wire

//--- logic/timer_pair.sv
// lower/upper word timer pair, chainable into one 32-bit timer
//
// Function
// - the lower-word timer can be chained with the upper-word timer into one 32-bit counter.
// - the lower-word timer gives an event that can start an analog conversion.
// - the lower timer's external input is synchronised after its prescaler.
// - the upper timer's external input is synchronised before its prescaler.
// - each timer has only free, gated and synchronous counter modes.
// - free and gated modes count the instruction-cycle clock.
// - synchronous counter mode counts the timer's external input pin.
// - bit 1 set selects synchronous counter mode regardless of the gate bit.
// - bit 6 picks gated (1) or free (0) mode when the internal clock is used.
// - bit 3 of the lower control word joins both timers into one 32-bit timer.
// - when joined the upper timer holds the high word, the lower the low word.
// - when joined only lower control bits matter, plus the upper idle-stop bit.
// - when joined the match event shows on the upper flag only.
`default_nettype none
module timer_pair (
  // clock and reset
  input  wire logic                    CLK,
  input  wire logic                    RST,
  // control words and periods
  input  wire logic [tmr_pkg::CW_W-1:0] CTRL_B,
  input  wire logic [tmr_pkg::CW_W-1:0] CTRL_C,
  input  wire logic [tmr_pkg::CW_W-1:0] PERIOD_B,
  input  wire logic [tmr_pkg::CW_W-1:0] PERIOD_C,
  input  wire logic                    IDLE,
  // pins
  input  wire logic                    EXT_COUNT_B,
  input  wire logic                    EXT_COUNT_C,
  input  wire logic                    GATE_B,
  input  wire logic                    GATE_C,
  // status
  output var  logic [tmr_pkg::CW_W-1:0] COUNT_B,
  output var  logic [tmr_pkg::CW_W-1:0] COUNT_C,
  output var  logic                    FLAG_B,
  output var  logic                    FLAG_C,
  output var  logic                    ADC_TRIGGER
);
  import tmr_pkg::*;

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [NPIN-1:0] pins;
  logic [NPIN-1:0] s1_r, s2_r, s3_r, lvl_r, rise_r;
  logic [NPIN-1:0] s1_nxt, s2_nxt, s3_nxt, lvl_nxt, rise_nxt;

  assign pins = {GATE_C, GATE_B, EXT_COUNT_C, EXT_COUNT_B};

  // a change counts once stages two and three agree
  always_comb begin
    s1_nxt   = pins;
    s2_nxt   = s1_r;
    s3_nxt   = s2_r;
    lvl_nxt  = lvl_r;
    rise_nxt = '0;
    for (int i = 0; i < NPIN; i++) begin
      if (s2_r[i] == s3_r[i]) begin
        lvl_nxt[i]  = s3_r[i];
        rise_nxt[i] = s3_r[i] & ~lvl_r[i];
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      s1_r   <= '0;
      s2_r   <= '0;
      s3_r   <= '0;
      lvl_r  <= '0;
      rise_r <= '0;
    end else begin
      s1_r   <= s1_nxt;
      s2_r   <= s2_nxt;
      s3_r   <= s3_nxt;
      lvl_r  <= lvl_nxt;
      rise_r <= rise_nxt;
    end
  end

  // ------------------------------------------------------------
  // mode decode and run control
  // ------------------------------------------------------------
  logic  chain, run_b, run_c;
  mode_t mode_b, mode_c;
  logic  ps_in_b, ps_in_c, ps_out_b, ps_out_c, tick_b, tick_c;

  assign chain  = CTRL_B[CHAIN_BIT];
  assign mode_b = mode_of(CTRL_B);
  assign mode_c = mode_of(CTRL_C);
  // upper idle-stop still halts the joined pair
  assign run_b  = CTRL_B[ON_BIT] & ~(IDLE & CTRL_B[IDLE_BIT])
                  & ~(chain & IDLE & CTRL_C[IDLE_BIT]);
  assign run_c  = ~chain & CTRL_C[ON_BIT] & ~(IDLE & CTRL_C[IDLE_BIT]);

  // source selection per mode
  function automatic logic src_of(input mode_t m, input logic run,
                                  input logic gate, input logic ext);
    case (m)
      MODE_FREE:  return run;
      MODE_GATED: return run & gate;
      MODE_SYNC:  return run & ext;
      default:    return 1'b0;
    endcase
  endfunction

  // lower timer: raw synchronised edge into prescaler, resync after
  assign ps_in_b = src_of(mode_b, run_b, lvl_r[PIN_GATE_B], rise_r[PIN_EXT_B]);
  // upper timer: already synchronised edge enters its prescaler
  assign ps_in_c = src_of(mode_c, run_c, lvl_r[PIN_GATE_C], rise_r[PIN_EXT_C]);

  tick_prescaler u_ps_b (
    .CLK      (CLK),
    .RST      (RST),
    .clear    (~run_b),
    .ratio    (CTRL_B[PS_HI:PS_LO]),
    .tick_in  (ps_in_b),
    .tick_out (ps_out_b)
  );

  tick_prescaler u_ps_c (
    .CLK      (CLK),
    .RST      (RST),
    .clear    (~run_c),
    .ratio    (CTRL_C[PS_HI:PS_LO]),
    .tick_in  (ps_in_c),
    .tick_out (ps_out_c)
  );

  // ------------------------------------------------------------
  // post-prescaler resync of the lower timer
  // ------------------------------------------------------------
  logic rs1_r, rs2_r, rs1_nxt, rs2_nxt;

  // costs two cycles of tick latency in counter mode only
  always_comb begin
    rs1_nxt = ps_out_b & run_b;
    rs2_nxt = rs1_r & run_b;
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      rs1_r <= 1'b0;
      rs2_r <= 1'b0;
    end else begin
      rs1_r <= rs1_nxt;
      rs2_r <= rs2_nxt;
    end
  end

  // tick in flight is dropped when the timer stops, except one already in rs2_r in counter mode
  assign tick_b = (mode_b == MODE_SYNC) ? rs2_r : (ps_out_b & run_b);
  assign tick_c = ps_out_c & run_c;

  // ------------------------------------------------------------
  // counters and events
  // ------------------------------------------------------------
  logic [CW_W-1:0]   cnt_b_r, cnt_c_r, cnt_b_nxt, cnt_c_nxt;
  logic              flag_b_r, flag_c_r, adc_r, flag_b_nxt, flag_c_nxt, adc_nxt;
  logic [2*CW_W-1:0] pair, pair_inc;
  logic              pair_match;

  assign pair       = {cnt_c_r, cnt_b_r};
  assign pair_inc   = pair + 32'h0000_0001;
  assign pair_match = (pair == {PERIOD_C, PERIOD_B});

  always_comb begin
    cnt_b_nxt  = cnt_b_r;
    cnt_c_nxt  = cnt_c_r;
    flag_b_nxt = 1'b0;
    flag_c_nxt = 1'b0;
    adc_nxt    = 1'b0;
    if (chain) begin
      if (tick_b) begin
        if (pair_match) begin
          cnt_b_nxt  = COUNT_RST;
          cnt_c_nxt  = COUNT_RST;
          flag_c_nxt = 1'b1;
          adc_nxt    = 1'b1;
        end else begin
          {cnt_c_nxt, cnt_b_nxt} = pair_inc;
        end
      end
    end else begin
      if (tick_b) begin
        if (cnt_b_r == PERIOD_B) begin
          cnt_b_nxt  = COUNT_RST;
          flag_b_nxt = 1'b1;
          adc_nxt    = 1'b1;
        end else begin
          cnt_b_nxt = cnt_b_r + 16'h0001;
        end
      end
      if (tick_c) begin
        if (cnt_c_r == PERIOD_C) begin
          cnt_c_nxt  = COUNT_RST;
          flag_c_nxt = 1'b1;
        end else begin
          cnt_c_nxt = cnt_c_r + 16'h0001;
        end
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      cnt_b_r  <= COUNT_RST;
      cnt_c_r  <= COUNT_RST;
      flag_b_r <= 1'b0;
      flag_c_r <= 1'b0;
      adc_r    <= 1'b0;
    end else begin
      cnt_b_r  <= cnt_b_nxt;
      cnt_c_r  <= cnt_c_nxt;
      flag_b_r <= flag_b_nxt;
      flag_c_r <= flag_c_nxt;
      adc_r    <= adc_nxt;
    end
  end

  assign COUNT_B     = cnt_b_r;
  assign COUNT_C     = cnt_c_r;
  assign FLAG_B      = flag_b_r;
  assign FLAG_C      = flag_c_r;
  assign ADC_TRIGGER = adc_r;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  AST_CHAIN_WRAP: assert property (chain && tick_b && pair_match |=>
    cnt_b_r == 16'h0000 && cnt_c_r == 16'h0000 && FLAG_C)
    else $error("joined pair did not wrap at period");
  AST_CHAIN_CARRY: assert property (chain && tick_b && !pair_match
    && cnt_b_r == 16'hffff |=> cnt_b_r == 16'h0000 && cnt_c_r == $past(cnt_c_r) + 16'h0001)
    else $error("low word carry lost in joined pair");
  AST_ADC_EVENT: assert property (!chain && tick_b && cnt_b_r == PERIOD_B
    |=> ADC_TRIGGER && FLAG_B)
    else $error("conversion trigger missing on lower match");
  AST_B_POST_SYNC: assert property (tick_b && mode_b == MODE_SYNC
    |-> $past(ps_out_b, 2))
    else $error("lower counter tick not delayed after prescaler");
  AST_C_PRE_SYNC: assert property (ps_in_c && mode_c == MODE_SYNC
    |-> rise_r[PIN_EXT_C])
    else $error("upper prescaler fed by unsynchronised input");
  AST_FREE_CLK: assert property (mode_b == MODE_FREE |-> ps_in_b == run_b)
    else $error("free mode not counting instruction clock");
  AST_GATE_SHUT: assert property (mode_b == MODE_GATED && !lvl_r[PIN_GATE_B]
    |-> !ps_in_b)
    else $error("gated mode counted with gate closed");
  AST_EXT_SRC: assert property (CTRL_B[CS_BIT]
    |-> ps_in_b == (run_b && rise_r[PIN_EXT_B]))
    else $error("counter mode not fed by external pin");
  AST_CHAIN_IGNORE: assert property (chain && $past(chain) |-> !FLAG_B && !ps_in_c)
    else $error("lower flag or upper source active while joined");
  AST_WRAP16: assert property (!chain && tick_c && cnt_c_r == PERIOD_C
    |=> cnt_c_r == 16'h0000 && FLAG_C)
    else $error("upper timer did not wrap at period");
  AST_PS_STOP: assert property (!run_b ##1 !run_b |-> !ps_out_b)
    else $error("prescaler ticked while stopped");

  COV_CHAIN_WRAP: cover property (chain && tick_b && pair_match);
  COV_EXT_COUNT: cover property (mode_c == MODE_SYNC && tick_c);
  COV_GATED_TICK: cover property (mode_b == MODE_GATED && tick_b);
endmodule
`default_nettype wire

//--- logic/tmr_pkg.sv
// shared constants, types and decode functions of the timer pair
`default_nettype none
package tmr_pkg;
  // ------------------------------------------------------------
  // control word layout
  // ------------------------------------------------------------
  localparam int CW_W       = 16;
  localparam int ON_BIT     = 15;
  localparam int IDLE_BIT   = 13;
  localparam int GATE_BIT   = 6;
  localparam int PS_HI      = 5;
  localparam int PS_LO      = 4;
  localparam int CHAIN_BIT  = 3;
  localparam int CS_BIT     = 1;
  // ------------------------------------------------------------
  // pin indices, widths, reset values
  // ------------------------------------------------------------
  localparam int PIN_EXT_B  = 0;
  localparam int PIN_EXT_C  = 1;
  localparam int PIN_GATE_B = 2;
  localparam int PIN_GATE_C = 3;
  localparam int NPIN       = 4;
  localparam int PS_W       = 8;
  localparam logic [CW_W-1:0] COUNT_RST = 16'h0000;
  localparam logic [PS_W-1:0] PS_RST    = 8'h00;

  typedef enum logic [1:0] {
    MODE_FREE  = 2'b00,
    MODE_GATED = 2'b01,
    MODE_SYNC  = 2'b10
  } mode_t;

  // clock source wins over gate bit
  function automatic mode_t mode_of(input logic [CW_W-1:0] w);
    if (w[CS_BIT]) begin
      return MODE_SYNC;
    end
    return w[GATE_BIT] ? MODE_GATED : MODE_FREE;
  endfunction

  // terminal count of the prescaler for 1:1, 1:8, 1:64, 1:256
  function automatic logic [PS_W-1:0] ps_limit(input logic [1:0] r);
    case (r)
      2'b00:   return 8'h00;
      2'b01:   return 8'h07;
      2'b10:   return 8'h3f;
      default: return 8'hff;
    endcase
  endfunction
endpackage
`default_nettype wire

//--- verification/ext_pin_model.sv
// far-side model: pulses an external count pin on request
`default_nettype none
module ext_pin_model (
  // clock and reset
  input  wire logic       CLK,
  input  wire logic       RST,
  // request
  input  wire logic       start,
  input  wire logic [7:0] count,
  // pin
  output wire logic       pin,
  output wire logic       busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] left_r;
  logic [2:0] ph_r;
  // 3 high, 3 low: wider than the 2-clock minimum of the pin sync
  always_ff @(posedge CLK) begin
    if (RST || start) begin
      left_r <= RST ? 8'h00 : count;
      ph_r   <= 3'h0;
    end else if (left_r != 8'h00) begin
      ph_r <= (ph_r == 3'h5) ? 3'h0 : ph_r + 3'h1;
      if (ph_r == 3'h5) begin
        left_r <= left_r - 8'h01;
      end
    end
  end
  assign pin  = (left_r != 8'h00) && (ph_r < 3'h3);
  assign busy = (left_r != 8'h00);
endmodule
`default_nettype wire

//--- verification/test_timer_pair.sv
// self-checking bench of the lower/upper timer pair
`default_nettype none
module test_timer_pair;
  timeunit 1ns;
  timeprecision 1ps;
  import tmr_pkg::*;
  logic            CLK = 1'b0;
  logic            RST = 1'b1;
  logic [CW_W-1:0] cb = '0, cc = '0, pb = '0, pc = '0, cnt_b, cnt_c;
  logic            idle = 1'b0, gb = 1'b0, gc = 1'b0, go_b = 1'b0, go_c = 1'b0;
  logic [7:0]      npul = 8'h00;
  logic            fb, fc, adc, pin_b, pin_c, busy_b, busy_c;
  int              checks = 0, bad_count = 0, cycles = 0;

  always #10 CLK = ~CLK;

  timer_pair uut (.CLK(CLK), .RST(RST), .CTRL_B(cb), .CTRL_C(cc), .PERIOD_B(pb),
    .PERIOD_C(pc), .IDLE(idle), .EXT_COUNT_B(pin_b), .EXT_COUNT_C(pin_c), .GATE_B(gb),
    .GATE_C(gc), .COUNT_B(cnt_b), .COUNT_C(cnt_c), .FLAG_B(fb), .FLAG_C(fc),
    .ADC_TRIGGER(adc));
  ext_pin_model pm_b (.CLK(CLK), .RST(RST), .start(go_b), .count(npul), .pin(pin_b),
    .busy(busy_b));
  ext_pin_model pm_c (.CLK(CLK), .RST(RST), .start(go_c), .count(npul), .pin(pin_c),
    .busy(busy_c));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic check_val(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask
  task automatic wait_fb(output int n);
    n = 0;
    while (fb !== 1'b1 && n < 2000) begin
      tick(1);
      n++;
    end
  endtask
  // fresh start: controls applied under reset
  task automatic setup(input logic [15:0] b, c, p, q);
    @(posedge CLK);
    RST <= 1'b1;
    cb  <= b;
    cc  <= c;
    pb  <= p;
    pc  <= q;
    @(posedge CLK);
    RST <= 1'b0;
    tick(1);
  endtask
  task automatic pulse(input bit upper, input logic [7:0] n);
    int m;
    @(posedge CLK);
    go_b <= !upper;
    go_c <= upper;
    npul <= n;
    @(posedge CLK);
    go_b <= 1'b0;
    go_c <= 1'b0;
    m = 0;
    tick(1);
    while ((busy_b || busy_c) && m < 200) begin
      tick(1);
      m++;
    end
    // room for sync, prescaler and resync latency after the last edge
    tick(10);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic free_wrap();
    int n;
    setup(16'h8000, 16'h8000, 16'h0002, 16'h0003);
    wait_fb(n);
    check_val("wrap count", 32'h0, 32'(cnt_b));
    check_val("adc", 32'h1, 32'(adc));
    check_val("upper count", 32'h3, 32'(cnt_c));
    tick(1);
    check_val("flag low", 32'h0, 32'(fb));
    check_val("count 1", 32'h1, 32'(cnt_b));
    check_val("upper wrap", 32'h0, 32'(cnt_c));
    check_val("upper flag", 32'h1, 32'(fc));
    tick(2);
    check_val("flag again", 32'h1, 32'(fb));
  endtask
  task automatic ratios();
    int n;
    int dv[4] = '{1, 8, 64, 256};
    for (int r = 0; r < 4; r++) begin
      setup(16'h8000 | 16'(r << 4), 16'h0000, 16'h0001, 16'h0000);
      wait_fb(n);
      tick(1);
      wait_fb(n);
      check_val("gap", 2 * dv[r], n + 1);
    end
  endtask
  task automatic gated();
    setup(16'h8040, 16'h0000, 16'hffff, 16'h0000);
    tick(20);
    check_val("gate shut", 32'h0, 32'(cnt_b));
    // 4 edges of pin sync, then prescaler and counter edges
    @(posedge CLK);
    gb <= 1'b1;
    tick(10);
    check_val("gate open", 32'h5, 32'(cnt_b));
    @(posedge CLK);
    gb <= 1'b0;
    tick(10);
    check_val("gate closed", 32'hb, 32'(cnt_b));
    tick(10);
    check_val("gate held", 32'hb, 32'(cnt_b));
  endtask
  task automatic ext_count();
    setup(16'h8042, 16'h0000, 16'hffff, 16'h0000);
    pulse(1'b0, 8'h05);
    check_val("pin lower", 32'h5, 32'(cnt_b));
    setup(16'h8052, 16'h0000, 16'hffff, 16'h0000);
    pulse(1'b0, 8'h08);
    check_val("pin lower 1:8", 32'h1, 32'(cnt_b));
    setup(16'h0000, 16'h8012, 16'h0000, 16'hffff);
    pulse(1'b1, 8'h10);
    check_val("pin upper 1:8", 32'h2, 32'(cnt_c));
    check_val("lower idle", 32'h0, 32'(cnt_b));
  endtask
  task automatic chained();
    int  n = 0;
    logic seen = 1'b0;
    // idle must already stand at the first run edge
    @(posedge CLK);
    idle <= 1'b1;
    setup(16'h8008, 16'h2000, 16'hffff, 16'hffff);
    tick(10);
    check_val("idle stop", 32'h0, {cnt_c, cnt_b});
    @(posedge CLK);
    idle <= 1'b0;
    // upper word junk must be ignored while joined
    setup(16'h8008, 16'h8042, 16'h0000, 16'h0001);
    while (cnt_c !== 16'h1 && n < 70000) begin
      tick(1);
      n++;
      seen = seen | fb;
    end
    check_val("carry", 32'h10000, {cnt_c, cnt_b});
    tick(1);
    check_val("joined wrap", 32'h0, {cnt_c, cnt_b});
    check_val("upper flag", 32'h1, 32'(fc));
    check_val("lower flag", 32'h0, 32'(seen | fb));
  endtask

  always @(posedge CLK) begin
    cycles++;
    if (cycles == 90000) begin
      bad_count++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (6) @(posedge CLK);
    RST <= 1'b0;
    free_wrap();
    ratios();
    gated();
    ext_count();
    chained();
    tally_and_finish();
  end
endmodule
`default_nettype wire
